// ==== rtl/pbc_bank.sv ====
// management register bank of a 10/100 transceiver, with serial port
// assumes mdc well below clk_in/4; straps hold steady around reset
`default_nettype none
module pbc_bank (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output var  logic        mdio_out,
  output var  logic        mdio_oe_out,
  input  wire logic [4:0]  phy_addr_in,
  input  wire logic        speed_strap_in,
  input  wire logic        negotiation_strap_pin,
  input  wire logic        isolate_strap_in,
  input  wire logic        duplex_strap_in,
  input  wire logic        neg_done_in,
  input  wire logic        neg_speed_100_in,
  input  wire logic        neg_full_duplex_in,
  input  wire logic        link_up_in,
  input  wire logic        jabber_in,
  input  wire logic        remote_fault_in,
  input  wire logic        receive_symbol_error,
  input  wire logic [15:0] partner_ability_in,
  input  wire logic [15:0] partner_next_page_in,
  output logic             soft_reset_out,
  output logic             restart_neg_out,
  output logic             neg_enable_out,
  output logic             speed_100_out,
  output logic             full_duplex_out,
  output logic             loopback_out,
  output logic             power_down_out,
  output logic             isolate_out,
  output logic             tx_disable_out,
  output logic             col_test_out
);
  import pbc_pkg::*;

  typedef enum {
    PBC_IDLE, PBC_START, PBC_OP, PBC_ADDR, PBC_TA, PBC_DATA
  } pbc_state_e;

  // pins and straps from outside the domain
  logic [6:0] pin_sync;
  logic [3:0] strap_s;
  pbc_sync #(.W(7)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({mdc_in, mdio_in, phy_addr_in}),
    .q_out  (pin_sync)
  );
  // straps keep flowing through reset so they are settled at release
  pbc_sync #(.W(4)) u_strap (
    .clk_in (clk_in),
    .rst_in (1'b0),
    .d_in   ({speed_strap_in, negotiation_strap_pin, isolate_strap_in,
              duplex_strap_in}),
    .q_out  (strap_s)
  );
  logic       mdc_s;
  logic       mdio_s;
  logic [4:0] paddr_s;
  assign mdc_s   = pin_sync[6];
  assign mdio_s  = pin_sync[5];
  assign paddr_s = pin_sync[4:0];

  // serial frame engine
  pbc_state_e   st_r, st_nxt;
  logic         mdc_d_r, mdc_d_nxt;
  logic [4:0]   cnt_r, cnt_nxt;
  logic [1:0]   op_r, op_nxt;
  logic [9:0]   adr_r, adr_nxt;
  logic [15:0]  sh_r, sh_nxt;
  logic         oe_r, oe_nxt;
  logic         do_r, do_nxt;
  logic         wr_r, wr_nxt;
  logic         rd_r, rd_nxt;
  logic [4:0]   wa_r, wa_nxt;
  logic         rise;
  logic         mine;
  logic [15:0]  rdata;

  assign rise = mdc_s & ~mdc_d_r;
  assign mine = (adr_r[9:5] == paddr_s);

  always_comb begin
    st_nxt    = st_r;
    mdc_d_nxt = mdc_s;
    cnt_nxt   = cnt_r;
    op_nxt    = op_r;
    adr_nxt   = adr_r;
    sh_nxt    = sh_r;
    oe_nxt    = oe_r;
    do_nxt    = do_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    wa_nxt    = wa_r;
    if (rise) begin
      unique case (st_r)
        // preamble is optional: any zero after idle ones is a start
        PBC_IDLE: begin
          oe_nxt = 1'b0;
          if (!mdio_s) st_nxt = PBC_START;
        end
        PBC_START: begin
          st_nxt  = mdio_s ? PBC_OP : PBC_IDLE;
          cnt_nxt = ZERO5;
        end
        PBC_OP: begin
          op_nxt  = {op_r[0], mdio_s};
          cnt_nxt = cnt_r + ONE5;
          if (cnt_r == ONE5) begin
            st_nxt  = PBC_ADDR;
            cnt_nxt = ZERO5;
          end
        end
        PBC_ADDR: begin
          adr_nxt = {adr_r[8:0], mdio_s};
          cnt_nxt = cnt_r + ONE5;
          if (cnt_r == ADDR_BITS - ONE5) begin
            st_nxt  = PBC_TA;
            cnt_nxt = ZERO5;
            if (op_r != OP_READ && op_r != OP_WRITE) st_nxt = PBC_IDLE;
          end
        end
        PBC_TA: begin
          cnt_nxt = cnt_r + ONE5;
          if (cnt_r == ZERO5) begin
            // first turnaround bit: drive zero only if addressed
            if (op_r == OP_READ && mine) begin
              oe_nxt = 1'b1;
              do_nxt = 1'b0;
              sh_nxt = rdata;
            end
          end else begin
            st_nxt  = PBC_DATA;
            cnt_nxt = ZERO5;
            if (oe_r) begin
              do_nxt = sh_r[15];
              sh_nxt = {sh_r[14:0], 1'b0};
            end
          end
        end
        PBC_DATA: begin
          cnt_nxt = cnt_r + ONE5;
          if (oe_r) begin
            do_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
          end else begin
            sh_nxt = {sh_r[14:0], mdio_s};
          end
          if (cnt_r == DATA_BITS - ONE5) begin
            st_nxt = PBC_IDLE;
            oe_nxt = 1'b0;
            rd_nxt = oe_r;
            if (op_r == OP_WRITE && mine) begin
              wr_nxt = 1'b1;
              wa_nxt = adr_r[4:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r    <= PBC_IDLE;
      mdc_d_r <= 1'b0;
      cnt_r   <= ZERO5;
      op_r    <= 2'b00;
      adr_r   <= 10'h000;
      sh_r    <= ZERO16;
      oe_r    <= 1'b0;
      do_r    <= 1'b0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      wa_r    <= ZERO5;
    end else begin
      st_r    <= st_nxt;
      mdc_d_r <= mdc_d_nxt;
      cnt_r   <= cnt_nxt;
      op_r    <= op_nxt;
      adr_r   <= adr_nxt;
      sh_r    <= sh_nxt;
      oe_r    <= oe_nxt;
      do_r    <= do_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      wa_r    <= wa_nxt;
    end
  end

  assign mdio_out    = do_r;
  assign mdio_oe_out = oe_r;

  // register storage; write data is the completed shift register
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] adv_r, adv_nxt;
  logic [15:0] npt_r, npt_nxt;
  logic [15:0] intr_r, intr_nxt;
  logic [15:0] vc1_r, vc1_nxt;
  logic [15:0] vc2_r, vc2_nxt;
  logic [15:0] rxe_r, rxe_nxt;
  logic        load_r, load_nxt;
  logic        srst_r, srst_nxt;
  logic        rstrt_r, rstrt_nxt;
  logic [15:0] strap_val;

  // straps are caught the cycle after reset release, never under reset
  always_comb begin
    strap_val          = CTRL_RST;
    strap_val[B_SPEED] = strap_s[3];
    strap_val[B_ANEN]  = strap_s[2];
    strap_val[B_ISO]   = strap_s[1];
    strap_val[B_DUPLEX] = ~strap_s[0];
  end

  always_comb begin
    ctrl_nxt  = ctrl_r;
    adv_nxt   = adv_r;
    npt_nxt   = npt_r;
    intr_nxt  = intr_r;
    vc1_nxt   = vc1_r;
    vc2_nxt   = vc2_r;
    rxe_nxt   = rxe_r;
    load_nxt  = 1'b0;
    srst_nxt  = 1'b0;
    rstrt_nxt = 1'b0;
    // counter halts in power down; a read clears it, a new error wins unless the count stood at CNT_MAX
    if (rd_r && adr_r[4:0] == ADDR_RXERR) rxe_nxt = ZERO16;
    if (receive_symbol_error && !ctrl_r[B_PDOWN] && rxe_r != CNT_MAX)
      rxe_nxt = rxe_nxt + 16'h0001;
    if (wr_r) begin
      unique case (wa_r)
        ADDR_CTRL: begin
          ctrl_nxt  = sh_r & CTRL_MASK;
          srst_nxt  = sh_r[B_SWRST];
          rstrt_nxt = sh_r[B_RESTART];
        end
        ADDR_ADV:  adv_nxt  = sh_r;
        ADDR_NPT:  npt_nxt  = sh_r;
        ADDR_INTR: intr_nxt = sh_r;
        ADDR_VC1:  vc1_nxt  = sh_r;
        ADDR_VC2:  vc2_nxt  = sh_r;
        default: begin
        end
      endcase
    end
    // software reset returns every register to its default
    if (srst_r || load_r) begin
      ctrl_nxt = strap_val;
      adv_nxt  = ZERO16;
      npt_nxt  = ZERO16;
      intr_nxt = ZERO16;
      vc1_nxt  = ZERO16;
      vc2_nxt  = ZERO16;
      rxe_nxt  = ZERO16;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r  <= CTRL_RST;
      adv_r   <= ZERO16;
      npt_r   <= ZERO16;
      intr_r  <= ZERO16;
      vc1_r   <= ZERO16;
      vc2_r   <= ZERO16;
      rxe_r   <= ZERO16;
      load_r  <= 1'b1;
      srst_r  <= 1'b0;
      rstrt_r <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      adv_r   <= adv_nxt;
      npt_r   <= npt_nxt;
      intr_r  <= intr_nxt;
      vc1_r   <= vc1_nxt;
      vc2_r   <= vc2_nxt;
      rxe_r   <= rxe_nxt;
      load_r  <= load_nxt;
      srst_r  <= srst_nxt;
      rstrt_r <= rstrt_nxt;
    end
  end

  // read mux; reserved addresses read zero
  always_comb begin
    rdata = ZERO16;
    unique case (adr_r[4:0])
      ADDR_CTRL: rdata = ctrl_r;
      ADDR_STAT: begin
        rdata           = STAT_FIXED;
        rdata[S_ANDONE] = neg_done_in;
        rdata[S_RFAULT] = remote_fault_in;
        rdata[S_LINK]   = link_up_in;
        rdata[S_JABBER] = jabber_in;
      end
      ADDR_IDH:   rdata = IDENT_HI;
      ADDR_IDL:   rdata = IDENT_LO;
      ADDR_ADV:   rdata = adv_r;
      ADDR_LPA:   rdata = partner_ability_in;
      ADDR_EXP:   rdata = ZERO16;
      ADDR_NPT:   rdata = npt_r;
      ADDR_LPNP:  rdata = partner_next_page_in;
      ADDR_RXERR: rdata = rxe_r;
      ADDR_INTR:  rdata = intr_r;
      ADDR_VC1:   rdata = vc1_r;
      ADDR_VC2:   rdata = vc2_r;
      default:    rdata = ZERO16;
    endcase
  end

  // effective mode outputs
  assign soft_reset_out  = srst_r;
  assign restart_neg_out = rstrt_r;
  assign neg_enable_out  = ctrl_r[B_ANEN];
  assign speed_100_out   = ctrl_r[B_ANEN] ? neg_speed_100_in
                                          : ctrl_r[B_SPEED];
  assign full_duplex_out = ctrl_r[B_ANEN] ? neg_full_duplex_in
                                          : ctrl_r[B_DUPLEX];
  assign loopback_out    = ctrl_r[B_LOOP];
  assign power_down_out  = ctrl_r[B_PDOWN];
  // power down also cuts the line side, management stays alive
  assign isolate_out     = ctrl_r[B_ISO] | ctrl_r[B_PDOWN];
  assign tx_disable_out  = ctrl_r[B_TXDIS] | ctrl_r[B_PDOWN];
  assign col_test_out    = ctrl_r[B_COLTEST];
endmodule
`default_nettype wire

// ==== rtl/pbc_pkg.sv ====
// constants for the transceiver management register bank
// assumes a 16-bit register space reached over a two-wire serial port
`default_nettype none
package pbc_pkg;
  localparam int         REG_W       = 16;
  localparam int         RADDR_W     = 5;
  // register numbers on the management port
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_STAT   = 5'h01;
  localparam logic [4:0] ADDR_IDH    = 5'h02;
  localparam logic [4:0] ADDR_IDL    = 5'h03;
  localparam logic [4:0] ADDR_ADV    = 5'h04;
  localparam logic [4:0] ADDR_LPA    = 5'h05;
  localparam logic [4:0] ADDR_EXP    = 5'h06;
  localparam logic [4:0] ADDR_NPT    = 5'h07;
  localparam logic [4:0] ADDR_LPNP   = 5'h08;
  localparam logic [4:0] ADDR_RXERR  = 5'h15;
  localparam logic [4:0] ADDR_INTR   = 5'h1b;
  localparam logic [4:0] ADDR_VC1    = 5'h1e;
  localparam logic [4:0] ADDR_VC2    = 5'h1f;
  // basic control field positions
  localparam int         B_SWRST     = 15;
  localparam int         B_LOOP      = 14;
  localparam int         B_SPEED     = 13;
  localparam int         B_ANEN      = 12;
  localparam int         B_PDOWN     = 11;
  localparam int         B_ISO       = 10;
  localparam int         B_RESTART   = 9;
  localparam int         B_DUPLEX    = 8;
  localparam int         B_COLTEST   = 7;
  localparam int         B_TXDIS     = 0;
  // stored control bits; self-clearing and reserved bits read zero
  localparam logic [15:0] CTRL_MASK  = 16'h7d81;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  // basic status: fixed capability bits (100 fd/hd, 10 fd/hd,
  // no preamble, negotiation ability, extended capability)
  localparam logic [15:0] STAT_FIXED = 16'h7849;
  localparam int         S_ANDONE    = 5;
  localparam int         S_RFAULT    = 4;
  localparam int         S_LINK      = 2;
  localparam int         S_JABBER    = 1;
  // arbitrary neutral identity values
  localparam logic [15:0] IDENT_HI   = 16'h1234;
  localparam logic [15:0] IDENT_LO   = 16'h5670;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  // serial frame
  localparam logic [1:0] OP_WRITE    = 2'b01;
  localparam logic [1:0] OP_READ     = 2'b10;
  localparam logic [4:0] ADDR_BITS   = 5'd10;
  localparam logic [4:0] DATA_BITS   = 5'd16;
  localparam logic [4:0] ONE5        = 5'd1;
  localparam logic [4:0] ZERO5       = 5'd0;
endpackage
`default_nettype wire

// ==== rtl/pbc_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
// assumes inputs change slowly compared with clk_in
`default_nettype none
module pbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
    end
  end
  assign q_out = s2_r;
endmodule
`default_nettype wire

// ==== tb/pbc_bank_sva.sv ====
// checker for the register bank outputs, bound into pbc_bank
// assumes straps steady around reset and one station on the port
`default_nettype none
module pbc_bank_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  input wire logic speed_strap_in,
  input wire logic negotiation_strap_pin,
  input wire logic isolate_strap_in,
  input wire logic duplex_strap_in,
  input wire logic neg_speed_100_in,
  input wire logic neg_full_duplex_in,
  input wire logic soft_reset_out,
  input wire logic restart_neg_out,
  input wire logic neg_enable_out,
  input wire logic speed_100_out,
  input wire logic full_duplex_out,
  input wire logic power_down_out,
  input wire logic isolate_out,
  input wire logic tx_disable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_reset_quiet: assert property ($fell(rst_in) |-> !mdio_oe_out
    && !soft_reset_out && !restart_neg_out) else $error("active at reset");
  a_swrst_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset pulse too long");
  a_restart_pulse: assert property (restart_neg_out |=> !restart_neg_out)
    else $error("restart pulse too long");
  a_speed_mux: assert property (neg_enable_out |->
    speed_100_out == neg_speed_100_in) else $error("speed not negotiated");
  a_duplex_mux: assert property (neg_enable_out |->
    full_duplex_out == neg_full_duplex_in) else $error("duplex wrong");
  a_pdown_iso: assert property (power_down_out |->
    isolate_out && tx_disable_out) else $error("power down leaks");
  a_strap_neg: assert property ($fell(rst_in) |-> ##2
    (neg_enable_out == negotiation_strap_pin
    && isolate_out == isolate_strap_in)) else $error("strap not loaded");
  a_strap_speed: assert property ($fell(rst_in) |-> ##2
    (negotiation_strap_pin || (speed_100_out == speed_strap_in
    && full_duplex_out == !duplex_strap_in))) else $error("strap speed");
  a_turn_drive: assert property ($rose(mdio_oe_out) |-> !mdio_out
    ##1 mdio_oe_out [*8]) else $error("turnaround drive wrong");
  c_swrst: cover property (soft_reset_out);
  c_restart: cover property (restart_neg_out);
  c_read: cover property ($rose(mdio_oe_out));
endmodule
bind pbc_bank pbc_bank_sva chk (.clk_in, .rst_in, .mdio_out, .mdio_oe_out,
  .speed_strap_in, .negotiation_strap_pin, .isolate_strap_in,
  .duplex_strap_in, .neg_speed_100_in, .neg_full_duplex_in,
  .soft_reset_out, .restart_neg_out, .neg_enable_out, .speed_100_out,
  .full_duplex_out, .power_down_out, .isolate_out, .tx_disable_out);
`default_nettype wire

// ==== tb/pbc_station.sv ====
// management station model driving the two-wire serial port
// assumes the bench resolves the data wire with a pull-up
`default_nettype none
module pbc_station import pbc_pkg::*; (
  input  wire logic clk_in,
  input  wire logic mdio_in,
  output var  logic mdc_out,
  output var  logic mdio_out,
  output var  logic mdio_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  // ten clocks a half period keeps mdc at 5 MHz, below the port limit
  task automatic half();
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  // frame without preamble; rd holds the turnaround bit then the data
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [16:0] rd);
    logic [31:0] bits;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 17'h00000;
    for (int i = 0; i < 32; i++) begin
      mdio_out = bits[31-i];
      mdio_oe_out = !(op == OP_READ && i > 13);
      half();
      if (i > 14) begin
        rd = {rd[15:0], mdio_in};
      end
      mdc_out = 1'b1;
      half();
      mdc_out = 1'b0;
    end
    mdio_oe_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/phy_basic_control_status_bench.sv ====
// self-checking bench for the management register bank
// assumes checker and station model are compiled before it
`default_nettype none
module phy_basic_control_status_bench import pbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_in, mdc_in, mdio_in, mdio_out, mdio_oe_out, st_d, st_oe;
  logic speed_strap_in, negotiation_strap_pin, isolate_strap_in;
  logic duplex_strap_in, neg_done_in, neg_speed_100_in, neg_full_duplex_in;
  logic link_up_in, jabber_in, remote_fault_in, receive_symbol_error;
  logic [4:0] phy_addr_in;
  logic [15:0] partner_ability_in, partner_next_page_in, outv;
  logic [16:0] junk;
  logic soft_reset_out, restart_neg_out, neg_enable_out, speed_100_out;
  logic full_duplex_out, loopback_out, power_down_out, isolate_out;
  logic tx_disable_out, col_test_out;
  logic [15:0] n_sr = 16'h0000;
  logic [15:0] n_rn = 16'h0000;
  int n_mismatch = 0;
  int check_count = 0;
  logic [4:0] res_list [7] = '{5'h08, 5'h09, 5'h14, 5'h16, 5'h1a,
                               5'h1c, 5'h1d};
  // released wire floats to the pull-up level
  assign mdio_in = mdio_oe_out ? mdio_out : (st_oe ? st_d : 1'b1);
  assign outv = {8'h00, neg_enable_out, speed_100_out, full_duplex_out,
                 loopback_out, power_down_out, isolate_out, tx_disable_out,
                 col_test_out};
  pbc_station st (.clk_in, .mdio_in, .mdc_out(mdc_in), .mdio_out(st_d),
                  .mdio_oe_out(st_oe));
  pbc_bank uut (.clk_in, .rst_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_out,
    .phy_addr_in, .speed_strap_in, .negotiation_strap_pin, .isolate_strap_in,
    .duplex_strap_in, .neg_done_in, .neg_speed_100_in, .neg_full_duplex_in,
    .link_up_in, .jabber_in, .remote_fault_in, .receive_symbol_error,
    .partner_ability_in, .partner_next_page_in, .soft_reset_out,
    .restart_neg_out, .neg_enable_out, .speed_100_out, .full_duplex_out,
    .loopback_out, .power_down_out, .isolate_out, .tx_disable_out,
    .col_test_out);
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_sr <= n_sr + {15'h0000, soft_reset_out};
    n_rn <= n_rn + {15'h0000, restart_neg_out};
  end
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
    logic [16:0] r;
    st.frame(OP_READ, phy_addr_in, ra, ZERO16, r);
    chk("turnaround", 16'h0000, {15'h0000, r[16]});
    chk("read data", exp, r[15:0]);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [16:0] r;
    st.frame(OP_WRITE, phy_addr_in, ra, d, r);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst_in = 1'b1;
    phy_addr_in = 5'h03;
    {speed_strap_in, negotiation_strap_pin} = 2'b10;
    {isolate_strap_in, duplex_strap_in} = 2'b11;
    {neg_done_in, neg_speed_100_in, neg_full_duplex_in} = 3'b001;
    {link_up_in, jabber_in, remote_fault_in} = 3'b100;
    receive_symbol_error = 1'b0;
    partner_ability_in = 16'h1e21;
    partner_next_page_in = 16'ha5c3;
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    rdchk(ADDR_CTRL, 16'h2400);
    chk("outputs", 16'h0044, outv);
    rdchk(ADDR_STAT, 16'h784d);
    wr(ADDR_CTRL, 16'h7dff);
    rdchk(ADDR_CTRL, 16'h7d81);
    chk("outputs", 16'h00bf, outv);
    wr(ADDR_CTRL, 16'h0401);
    chk("outputs", 16'h0006, outv);
    wr(ADDR_CTRL, 16'h2300);
    chk("restart pulses", 16'h0001, n_rn);
    rdchk(ADDR_CTRL, 16'h2100);
    chk("outputs", 16'h0060, outv);
    // a frame for another device address must not land here
    wr(ADDR_ADV, 16'h1e21);
    st.frame(OP_WRITE, phy_addr_in ^ 5'h01, ADDR_ADV, 16'hffff, junk);
    rdchk(ADDR_ADV, 16'h1e21);
    wr(ADDR_CTRL, 16'h8000);
    chk("soft reset pulses", 16'h0001, n_sr);
    rdchk(ADDR_CTRL, 16'h2400);
    rdchk(ADDR_ADV, ZERO16);
    // a write to a reserved place must leave nothing behind
    wr(5'h09, 16'hffff);
    foreach (res_list[i]) begin
      rdchk(res_list[i], (i == 0) ? partner_next_page_in : ZERO16);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
